// File: router_node_config_bank.sv
/*
 * Router node configuration and status register bank with clock
 * multiplier control, routing table lookup, halt line and link status.
 * Assumes a simple configuration port synchronous to CLK, one access
 * per cycle, and link status inputs synchronous to CLK.
 */
`timescale 1ns/1ps
// Behaviour
// - Node identity 16 bits writable, reset zero
// - Multiplier settings write resets the tile
// - Bit 31 set suppresses the chip reset
// - Bit 30 set skips waiting for relock
// - Bit 29 set bypasses the multiplier
// - Bit 28 set selects test-port boot source
// - Output divider field holds ratio minus one
// - Feedback field holds multiply ratio minus one
// - Input divider field holds ratio minus one
// - Router clock divider 16 bits, reset zero
// - Reference clock divider 16 bits, reset three
// - User code register returns fixed codes
// - Route by highest differing identifier bit
// - Low table holds dimensions 0 to 7
// - High table holds dimensions 8 to 15
// - Tile bit 1 lets line request halt
// - Tile bit 0 lets halted flag drive line
// - Origin register records latest halt source
// - Link register reports source target kind
// - Link register reports destination link number
// - Link direction and network fields writable
// - Link register reports junk and use flags
module router_node_config_bank #(
	parameter logic [31:0] TAP_DEVICE_ID = 32'h1234_5001, // Value arbitrary
	parameter logic [13:0] OTP_USER_CODE = 14'h0000,
	parameter logic [17:0] METAL_ID_CODE = 18'h00001       // Value arbitrary
) (
	// Clock and reset
	input  wire logic                                    CLK,
	input  wire logic                                    RESET_N,
	// Configuration access
	input  wire logic                                    CFG_WR,
	input  wire logic                                    CFG_RD,
	input  wire logic [7:0]                              CFG_ADDR,
	input  wire logic [31:0]                             CFG_WDATA,
	output logic [31:0]                                  CFG_RDATA,
	output logic                                         CFG_RVALID,
	// Clock multiplier
	input  wire logic                                    MULT_LOCKED,
	output node_cfg_pkg::clk_mult_type                   CLK_MULT,
	output logic                                         CLK_MULT_APPLY,
	output logic                                         TILE_RESET,
	output logic                                         MULT_WAITING,
	output logic [15:0]                                  ROUTER_DIV,
	output logic [15:0]                                  REF_DIV,
	// Routing decisions
	input  wire logic                                    PKT_VALID,
	input  wire logic [15:0]                             PKT_DEST_ID,
	output logic                                         ROUTE_VALID,
	output logic                                         ROUTE_LOCAL,
	output logic [3:0]                                   ROUTE_DIR,
	// Shared halt line, active low open drain
	input  wire logic                                    HALT_LINE_N_I,
	output logic                                         HALT_LINE_N_O,
	output logic                                         HALT_LINE_N_OE,
	input  wire logic [1:0]                              CORE_HALTED_FLAG,
	output logic [1:0]                                   CORE_HALT_REQ,
	// Links
	input  node_cfg_pkg::link_state_type [7:0]           LINK_STATE,
	output logic [31:0]                                  LINK_DIR,
	output logic [15:0]                                  LINK_NET
);

	logic                                rst_meta_q;
	logic                                rst_sync_q;
	logic [15:0]                         node_id_q;
	node_cfg_pkg::clk_mult_type          clk_mult_q;
	logic                                apply_q;
	logic                                tile_rst_q;
	node_cfg_pkg::lock_state_type        lock_q;
	logic [15:0]                         router_div_q;
	logic [15:0]                         ref_div_q;
	logic [31:0]                         dir_low_q;
	logic [31:0]                         dir_high_q;
	logic [1:0]                          dbg_tile0_q;
	logic [1:0]                          dbg_tile1_q;
	logic [2:0]                          origin_reg_q;
	logic [3:0]                          link_dir_q [8];
	logic [1:0]                          link_net_q [8];
	logic [31:0]                         rdata_q;
	logic                                rvalid_q;
	logic                                route_valid_q;
	logic                                route_local_q;
	logic [3:0]                          route_dir_q;
	logic                                pin_o_q;
	logic                                line_drive;
	logic [1:0]                          halt_req;
	logic                                origin_evt;
	logic [2:0]                          origin_src;
	logic                                lookup_local;
	logic [3:0]                          lookup_dir;
	logic                                wr_mult;
	logic [31:0]                         rd_word;

	function automatic logic hit(input logic [7:0] a, input logic [7:0] idx);
		return a == idx;
	endfunction : hit

	function automatic logic link_hit(input logic [7:0] a);
		return (a >= node_cfg_pkg::IDX_LINK_BASE) && (a <= node_cfg_pkg::IDX_LINK_LAST);
	endfunction : link_hit

	// Reset release through two flops
	always_ff @(posedge CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end

	assign wr_mult = CFG_WR && hit(CFG_ADDR, node_cfg_pkg::IDX_CLK_MULT);

	// Node identity and clock dividers
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			node_id_q    <= node_cfg_pkg::RST_NODE_ID;
			router_div_q <= node_cfg_pkg::RST_ROUTER_DIV;
			ref_div_q    <= node_cfg_pkg::RST_REF_DIV;
		end else if (CFG_WR) begin
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_NODE_ID)) begin
				node_id_q <= CFG_WDATA[15:0];
			end
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_ROUTER_DIV)) begin
				router_div_q <= CFG_WDATA[15:0];
			end
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_REF_DIV)) begin
				ref_div_q <= CFG_WDATA[15:0];
			end
		end
	end

	// Multiplier settings; fields hold ratio minus one
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			clk_mult_q <= '{
				p_div:    node_cfg_pkg::RST_CLK_MULT[node_cfg_pkg::CM_P_LSB +: node_cfg_pkg::CM_P_W],
				m_mul:    node_cfg_pkg::RST_CLK_MULT[node_cfg_pkg::CM_M_LSB +: node_cfg_pkg::CM_M_W],
				n_div:    node_cfg_pkg::RST_CLK_MULT[node_cfg_pkg::CM_N_LSB +: node_cfg_pkg::CM_N_W],
				bypass:   node_cfg_pkg::RST_CLK_MULT[node_cfg_pkg::CM_BYPASS],
				tap_boot: node_cfg_pkg::RST_CLK_MULT[node_cfg_pkg::CM_TAP_BOOT]
			};
		end else if (wr_mult) begin
			clk_mult_q.p_div    <= CFG_WDATA[node_cfg_pkg::CM_P_LSB +: node_cfg_pkg::CM_P_W];
			clk_mult_q.m_mul    <= CFG_WDATA[node_cfg_pkg::CM_M_LSB +: node_cfg_pkg::CM_M_W];
			clk_mult_q.n_div    <= CFG_WDATA[node_cfg_pkg::CM_N_LSB +: node_cfg_pkg::CM_N_W];
			clk_mult_q.bypass   <= CFG_WDATA[node_cfg_pkg::CM_BYPASS];
			clk_mult_q.tap_boot <= CFG_WDATA[node_cfg_pkg::CM_TAP_BOOT];
		end
	end

	// Apply pulse and tile reset pulse after a settings write
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			apply_q    <= 1'b0;
			tile_rst_q <= 1'b0;
		end else begin
			apply_q    <= wr_mult;
			tile_rst_q <= wr_mult && !CFG_WDATA[node_cfg_pkg::CM_KEEP_CHIP];
		end
	end

	// Relock wait, skipped when the write asks for it
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			lock_q <= node_cfg_pkg::LOCK_IDLE;
		end else begin
			unique case (lock_q)
				node_cfg_pkg::LOCK_IDLE: begin
					if (wr_mult && !CFG_WDATA[node_cfg_pkg::CM_SKIP_RELOCK]) begin
						lock_q <= node_cfg_pkg::LOCK_WAIT;
					end
				end
				node_cfg_pkg::LOCK_WAIT: begin
					if (wr_mult && CFG_WDATA[node_cfg_pkg::CM_SKIP_RELOCK]) begin
						lock_q <= node_cfg_pkg::LOCK_IDLE;
					end else if (MULT_LOCKED && !wr_mult) begin
						lock_q <= node_cfg_pkg::LOCK_IDLE;
					end
				end
				default: begin
					lock_q <= node_cfg_pkg::LOCK_IDLE;
				end
			endcase
		end
	end

	// Direction tables and halt line configuration
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			dir_low_q   <= 32'h0000_0000;
			dir_high_q  <= 32'h0000_0000;
			dbg_tile0_q <= 2'h0;
			dbg_tile1_q <= 2'h0;
		end else if (CFG_WR) begin
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_DIR_LOW)) begin
				dir_low_q <= CFG_WDATA;
			end
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_DIR_HIGH)) begin
				dir_high_q <= CFG_WDATA;
			end
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_TILE0)) begin
				dbg_tile0_q <= CFG_WDATA[1:0];
			end
			if (hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_TILE1)) begin
				dbg_tile1_q <= CFG_WDATA[1:0];
			end
		end
	end

	// Origin record: a new halt event wins over a software write
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			origin_reg_q <= 3'h0;
		end else if (origin_evt) begin
			origin_reg_q <= origin_src;
		end else if (CFG_WR && hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_ORIGIN)) begin
			origin_reg_q <= {CFG_WDATA[node_cfg_pkg::ORG_EXT],
			                 CFG_WDATA[node_cfg_pkg::ORG_CORE1],
			                 CFG_WDATA[node_cfg_pkg::ORG_CORE0]};
		end
	end

	// Per-link direction and network fields
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			for (int i = 0; i < 8; i++) begin
				link_dir_q[i] <= 4'h0;
				link_net_q[i] <= 2'h0;
			end
		end else if (CFG_WR && link_hit(CFG_ADDR)) begin
			link_dir_q[CFG_ADDR[2:0]] <= CFG_WDATA[node_cfg_pkg::LNK_DIR_LSB +: 4];
			link_net_q[CFG_ADDR[2:0]] <= CFG_WDATA[node_cfg_pkg::LNK_NET_LSB +: 2];
		end
	end

	// Read word selection; reserved bits and unmapped indices read zero
	always_comb begin
		rd_word = 32'h0000_0000;
		if (link_hit(CFG_ADDR)) begin
			rd_word[node_cfg_pkg::LNK_KIND_LSB +: 2] = LINK_STATE[CFG_ADDR[2:0]].kind;
			rd_word[node_cfg_pkg::LNK_DEST_LSB +: 8] = LINK_STATE[CFG_ADDR[2:0]].dest_link;
			rd_word[node_cfg_pkg::LNK_DIR_LSB +: 4]  = link_dir_q[CFG_ADDR[2:0]];
			rd_word[node_cfg_pkg::LNK_NET_LSB +: 2]  = link_net_q[CFG_ADDR[2:0]];
			rd_word[node_cfg_pkg::LNK_JUNK]    = LINK_STATE[CFG_ADDR[2:0]].junk;
			rd_word[node_cfg_pkg::LNK_DST_USE] = LINK_STATE[CFG_ADDR[2:0]].dst_in_use;
			rd_word[node_cfg_pkg::LNK_SRC_USE] = LINK_STATE[CFG_ADDR[2:0]].src_in_use;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_NODE_ID)) begin
			rd_word[15:0] = node_id_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_CLK_MULT)) begin
			rd_word[node_cfg_pkg::CM_P_LSB +: node_cfg_pkg::CM_P_W] = clk_mult_q.p_div;
			rd_word[node_cfg_pkg::CM_M_LSB +: node_cfg_pkg::CM_M_W] = clk_mult_q.m_mul;
			rd_word[node_cfg_pkg::CM_N_LSB +: node_cfg_pkg::CM_N_W] = clk_mult_q.n_div;
			rd_word[node_cfg_pkg::CM_BYPASS]   = clk_mult_q.bypass;
			rd_word[node_cfg_pkg::CM_TAP_BOOT] = clk_mult_q.tap_boot;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_ROUTER_DIV)) begin
			rd_word[15:0] = router_div_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_REF_DIV)) begin
			rd_word[15:0] = ref_div_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_TAP_ID)) begin
			rd_word = TAP_DEVICE_ID;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_USER_CODE)) begin
			rd_word = {OTP_USER_CODE, METAL_ID_CODE};
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_DIR_LOW)) begin
			rd_word = dir_low_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_DIR_HIGH)) begin
			rd_word = dir_high_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_TILE0)) begin
			rd_word[1:0] = dbg_tile0_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_TILE1)) begin
			rd_word[1:0] = dbg_tile1_q;
		end else if (hit(CFG_ADDR, node_cfg_pkg::IDX_DBG_ORIGIN)) begin
			rd_word[node_cfg_pkg::ORG_EXT]   = origin_reg_q[2];
			rd_word[node_cfg_pkg::ORG_CORE1] = origin_reg_q[1];
			rd_word[node_cfg_pkg::ORG_CORE0] = origin_reg_q[0];
		end
	end

	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			rdata_q  <= 32'h0000_0000;
			rvalid_q <= 1'b0;
		end else begin
			rvalid_q <= CFG_RD;
			if (CFG_RD) begin
				rdata_q <= rd_word;
			end
		end
	end

	route_lookup u_route (
		.node_id   (node_id_q),
		.dest_id   (PKT_DEST_ID),
		.dir_table ({dir_high_q, dir_low_q}),
		.is_local  (lookup_local),
		.direction (lookup_dir)
	);

	// Routing result one cycle after the request
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			route_valid_q <= 1'b0;
			route_local_q <= 1'b0;
			route_dir_q   <= 4'h0;
		end else begin
			route_valid_q <= PKT_VALID;
			if (PKT_VALID) begin
				route_local_q <= lookup_local;
				route_dir_q   <= lookup_local ? 4'h0 : lookup_dir;
			end
		end
	end

	halt_line_ctrl u_halt (
		.clk              (CLK),
		.rst_n            (rst_sync_q),
		.halt_in_en       ({dbg_tile1_q[node_cfg_pkg::DBG_HALT_IN],
		                    dbg_tile0_q[node_cfg_pkg::DBG_HALT_IN]}),
		.drive_en         ({dbg_tile1_q[node_cfg_pkg::DBG_DRIVE_OUT],
		                    dbg_tile0_q[node_cfg_pkg::DBG_DRIVE_OUT]}),
		.core_halted_flag (CORE_HALTED_FLAG),
		.line_n_in        (HALT_LINE_N_I),
		.line_drive_q     (line_drive),
		.halt_req_q       (halt_req),
		.origin_evt_q     (origin_evt),
		.origin_q         (origin_src)
	);

	// Open-drain line only ever pulls low
	always_ff @(posedge CLK or negedge rst_sync_q) begin
		if (!rst_sync_q) begin
			pin_o_q <= 1'b0;
		end else begin
			pin_o_q <= 1'b0;
		end
	end

	assign CFG_RDATA      = rdata_q;
	assign CFG_RVALID     = rvalid_q;
	assign CLK_MULT       = clk_mult_q;
	assign CLK_MULT_APPLY = apply_q;
	assign TILE_RESET     = tile_rst_q;
	assign MULT_WAITING   = lock_q[1];
	assign ROUTER_DIV     = router_div_q;
	assign REF_DIV        = ref_div_q;
	assign ROUTE_VALID    = route_valid_q;
	assign ROUTE_LOCAL    = route_local_q;
	assign ROUTE_DIR      = route_dir_q;
	assign HALT_LINE_N_O  = pin_o_q;
	assign HALT_LINE_N_OE = line_drive;
	assign CORE_HALT_REQ  = halt_req;

	always_comb begin
		for (int i = 0; i < 8; i++) begin
			LINK_DIR[i*4 +: 4] = link_dir_q[i];
			LINK_NET[i*2 +: 2] = link_net_q[i];
		end
	end

endmodule : router_node_config_bank

// File: node_cfg_pkg.sv
/*
 * Shared definitions of the router node configuration bank: register
 * indices, field positions, reset values, carrier types and state codes.
 * Assumes the configuration port addresses registers by their index.
 */
package node_cfg_pkg;

	localparam int unsigned ADDR_W      = 8;
	localparam int unsigned DATA_W      = 32;
	localparam int unsigned NODE_ID_W   = 16;
	localparam int unsigned DIR_W       = 4;
	localparam int unsigned NET_W       = 2;
	localparam int unsigned NUM_LINKS   = 8;
	localparam int unsigned NUM_TILES   = 2;
	localparam int unsigned NUM_DIMS    = 16;

	// Register indices
	localparam logic [7:0] IDX_NODE_ID    = 8'h05;
	localparam logic [7:0] IDX_CLK_MULT   = 8'h06;
	localparam logic [7:0] IDX_ROUTER_DIV = 8'h07;
	localparam logic [7:0] IDX_REF_DIV    = 8'h08;
	localparam logic [7:0] IDX_TAP_ID     = 8'h09;
	localparam logic [7:0] IDX_USER_CODE  = 8'h0a;
	localparam logic [7:0] IDX_DIR_LOW    = 8'h0c;
	localparam logic [7:0] IDX_DIR_HIGH   = 8'h0d;
	localparam logic [7:0] IDX_DBG_TILE0  = 8'h10;
	localparam logic [7:0] IDX_DBG_TILE1  = 8'h11;
	localparam logic [7:0] IDX_DBG_ORIGIN = 8'h1f;
	localparam logic [7:0] IDX_LINK_BASE  = 8'h20;
	localparam logic [7:0] IDX_LINK_LAST  = 8'h27;

	// Clock multiplier settings fields
	localparam int unsigned CM_KEEP_CHIP   = 31;
	localparam int unsigned CM_SKIP_RELOCK = 30;
	localparam int unsigned CM_BYPASS      = 29;
	localparam int unsigned CM_TAP_BOOT    = 28;
	localparam int unsigned CM_P_LSB       = 23;
	localparam int unsigned CM_P_W         = 3;
	localparam int unsigned CM_M_LSB       = 8;
	localparam int unsigned CM_M_W         = 13;
	localparam int unsigned CM_N_LSB       = 0;
	localparam int unsigned CM_N_W         = 7;

	// Debug fields
	localparam int unsigned DBG_HALT_IN   = 1;
	localparam int unsigned DBG_DRIVE_OUT = 0;
	localparam int unsigned ORG_EXT       = 4;
	localparam int unsigned ORG_CORE1     = 1;
	localparam int unsigned ORG_CORE0     = 0;

	// Link register fields
	localparam int unsigned LNK_KIND_LSB = 24;
	localparam int unsigned LNK_DEST_LSB = 16;
	localparam int unsigned LNK_DIR_LSB  = 8;
	localparam int unsigned LNK_NET_LSB  = 4;
	localparam int unsigned LNK_JUNK     = 2;
	localparam int unsigned LNK_DST_USE  = 1;
	localparam int unsigned LNK_SRC_USE  = 0;

	// Reset values
	localparam logic [15:0] RST_NODE_ID    = 16'h0000;
	localparam logic [15:0] RST_ROUTER_DIV = 16'h0000;
	localparam logic [15:0] RST_REF_DIV    = 16'h0003;
	localparam logic [31:0] RST_CLK_MULT   = 32'h0000_0000;

	typedef enum logic [1:0] {
		LOCK_IDLE = 2'b01,
		LOCK_WAIT = 2'b10
	} lock_state_type;

	// Source target kinds
	typedef enum logic [1:0] {
		KIND_EXT_ROUTER_LINK  = 2'h0,
		KIND_PROCESSOR_LINK   = 2'h1,
		KIND_ROUTER_CONTROL   = 2'h2,
		KIND_UNDEFINED        = 2'h3
	} source_target_kind_type;

	typedef struct packed {
		source_target_kind_type kind;
		logic [7:0]             dest_link;
		logic                   junk;
		logic                   dst_in_use;
		logic                   src_in_use;
	} link_state_type;

	typedef struct packed {
		logic [CM_P_W-1:0] p_div;
		logic [CM_M_W-1:0] m_mul;
		logic [CM_N_W-1:0] n_div;
		logic              bypass;
		logic              tap_boot;
	} clk_mult_type;

endpackage : node_cfg_pkg

// File: route_lookup.sv
/*
 * Combinational routing decision: local delivery or the direction entry
 * of the highest differing identifier bit.
 * Assumes the caller registers the result.
 */
`timescale 1ns/1ps
module route_lookup (
	// Identities
	input  wire logic [15:0] node_id,
	input  wire logic [15:0] dest_id,
	// Direction table, dimension k at bits 4k+3..4k
	input  wire logic [63:0] dir_table,
	// Decision
	output logic             is_local,
	output logic [3:0]       direction
);

	function automatic logic [3:0] top_bit(input logic [15:0] v);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (v[i]) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction : top_bit

	logic [15:0] diff;
	logic [3:0]  dim;

	assign diff      = node_id ^ dest_id;
	assign dim       = top_bit(diff);
	assign is_local  = (diff == 16'h0000);
	assign direction = dir_table[{dim, 2'b00} +: 4];

endmodule : route_lookup

// File: halt_line_ctrl.sv
/*
 * Shared halt line control for two tiles: drive, halt requests and origin
 * events. Assumes the line input is active low and synchronous to clk.
 */
`timescale 1ns/1ps
module halt_line_ctrl (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// Configuration per tile
	input  wire logic [1:0] halt_in_en,
	input  wire logic [1:0] drive_en,
	// Cores and line
	input  wire logic [1:0] core_halted_flag,
	input  wire logic       line_n_in,
	// Results
	output logic            line_drive_q,
	output logic [1:0]      halt_req_q,
	output logic            origin_evt_q,
	output logic [2:0]      origin_q
);

	logic [1:0] drivers;
	logic       asserted;
	logic       asserted_q;

	assign drivers  = drive_en & core_halted_flag;
	assign asserted = ~line_n_in | (|drivers);

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			line_drive_q <= 1'b0;
			halt_req_q   <= 2'b00;
		end else begin
			line_drive_q <= |drivers;
			halt_req_q   <= halt_in_en & {2{asserted}};
		end
	end

	// Origin {external, core1, core0} caught at each new assertion
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			asserted_q   <= 1'b0;
			origin_evt_q <= 1'b0;
			origin_q     <= 3'h0;
		end else begin
			asserted_q   <= asserted;
			origin_evt_q <= asserted & ~asserted_q;
			origin_q     <= {~(|drivers) & ~line_n_in, drivers};
		end
	end

endmodule : halt_line_ctrl

// File: router_node_config_bank_checker.sv
/* Port assertions of the router node configuration bank.
   Assumes binding to the top module and no traffic before reset settles. */
`timescale 1ns/1ps
module router_node_config_bank_checker (
	// Clock, reset and configuration port
	input wire logic                       CLK,
	input wire logic                       RESET_N,
	input wire logic                       CFG_WR,
	input wire logic                       CFG_RD,
	input wire logic [7:0]                 CFG_ADDR,
	input wire logic [31:0]                CFG_WDATA,
	input wire logic                       CFG_RVALID,
	// Clock multiplier
	input wire logic                       MULT_LOCKED,
	input wire node_cfg_pkg::clk_mult_type CLK_MULT,
	input wire logic                       CLK_MULT_APPLY,
	input wire logic                       TILE_RESET,
	input wire logic                       MULT_WAITING,
	// Routing
	input wire logic                       PKT_VALID,
	input wire logic                       ROUTE_VALID,
	input wire logic                       ROUTE_LOCAL,
	input wire logic [3:0]                 ROUTE_DIR
);
	logic wm;
	assign wm = CFG_WR && CFG_ADDR == node_cfg_pkg::IDX_CLK_MULT;
	default clocking @(posedge CLK); endclocking
	default disable iff (!RESET_N);
	AST_RVALID: assert property (CFG_RD |=> CFG_RVALID) else $error("read not answered");
	AST_NO_RVALID: assert property (!CFG_RD |=> !CFG_RVALID) else $error("stray read answer");
	AST_TILE_RST: assert property (wm |=> TILE_RESET == !$past(CFG_WDATA[31]))
		else $error("tile reset wrong");
	AST_WAIT: assert property (wm && !CFG_WDATA[30] |=> MULT_WAITING) else $error("no relock wait");
	AST_NO_WAIT: assert property (wm && CFG_WDATA[30] |=> !MULT_WAITING) else $error("wait not skipped");
	AST_RELOCK: assert property (MULT_WAITING && MULT_LOCKED && !wm |=> !MULT_WAITING)
		else $error("lock not taken");
	AST_APPLY: assert property (CLK_MULT_APPLY == $past(wm)) else $error("apply pulse wrong");
	AST_MODES: assert property (wm |=> CLK_MULT[1:0] == $past(CFG_WDATA[29:28]))
		else $error("bypass or boot wrong");
	AST_RATIOS: assert property (wm |=> CLK_MULT[24:2] ==
		{$past(CFG_WDATA[25:23]), $past(CFG_WDATA[20:8]), $past(CFG_WDATA[6:0])}) else $error("ratios wrong");
	AST_ROUTE: assert property (PKT_VALID |=> ROUTE_VALID) else $error("route not answered");
	AST_LOCAL: assert property (ROUTE_VALID && ROUTE_LOCAL |-> ROUTE_DIR == 4'h0) else $error("local dir");
endmodule : router_node_config_bank_checker
bind router_node_config_bank router_node_config_bank_checker chk_u (.CLK, .RESET_N, .CFG_WR, .CFG_RD,
	.CFG_ADDR, .CFG_WDATA, .CFG_RVALID, .MULT_LOCKED, .CLK_MULT, .CLK_MULT_APPLY, .TILE_RESET,
	.MULT_WAITING, .PKT_VALID,
	.ROUTE_VALID, .ROUTE_LOCAL, .ROUTE_DIR);

// File: tb_router_node_config_bank.sv
/* Self-checking bench of the configuration bank against a register model.
   Assumes the design package and the checker are compiled first. */
`timescale 1ns/1ps
module tb_router_node_config_bank;
	logic        CLK = 0, RESET_N = 0, CFG_WR = 0, CFG_RD = 0, MULT_LOCKED = 1, PKT_VALID = 0;
	logic        CFG_RVALID, CLK_MULT_APPLY, TILE_RESET, MULT_WAITING, ROUTE_VALID, ROUTE_LOCAL;
	logic        HALT_LINE_N_O, HALT_LINE_N_OE, ext_n = 1;
	logic [7:0]  CFG_ADDR = 0, a, lst [0:7] = '{8'h05, 8'h06, 8'h07, 8'h08, 8'h0c, 8'h0d, 8'h10, 8'h11};
	logic [31:0] CFG_WDATA = 0, CFG_RDATA, LINK_DIR, md [0:255];
	logic [15:0] PKT_DEST_ID = 0, ROUTER_DIV, REF_DIV, LINK_NET, lf = 16'hda90, t;
	logic [1:0]  CORE_HALTED_FLAG = 0, CORE_HALT_REQ;
	logic [3:0]  ROUTE_DIR;
	logic [63:0] tab;
	node_cfg_pkg::clk_mult_type         CLK_MULT;
	node_cfg_pkg::link_state_type [7:0] LINK_STATE = '0;
	int          n_fail = 0, compares = 0, cyc = 0, k;
	// Open-drain wire: low when the bank pulls or the outside pulls
	wire         HALT_LINE_N_I = ext_n & ~(HALT_LINE_N_OE & ~HALT_LINE_N_O);
	// Identity values are arbitrary
	router_node_config_bank #(.TAP_DEVICE_ID(32'h0abc_0001), .OTP_USER_CODE(14'h02a5),
		.METAL_ID_CODE(18'h1_0203)) dut_u (.CLK, .RESET_N, .CFG_WR, .CFG_RD, .CFG_ADDR, .CFG_WDATA,
		.CFG_RDATA, .CFG_RVALID, .MULT_LOCKED, .CLK_MULT, .CLK_MULT_APPLY, .TILE_RESET, .MULT_WAITING,
		.ROUTER_DIV, .REF_DIV, .PKT_VALID, .PKT_DEST_ID, .ROUTE_VALID, .ROUTE_LOCAL, .ROUTE_DIR,
		.HALT_LINE_N_I, .HALT_LINE_N_O, .HALT_LINE_N_OE, .CORE_HALTED_FLAG, .CORE_HALT_REQ,
		.LINK_STATE, .LINK_DIR, .LINK_NET);
	always #20 CLK = ~CLK;
	always @(posedge CLK) begin
		cyc++;
		if (cyc == 5000) begin
			n_fail++;
			complete_run();
		end
	end
	function automatic logic [15:0] rnd();
		lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
		return lf;
	endfunction : rnd
	function automatic logic [31:0] wmask(input logic [7:0] r);
		case (r)
			8'h05, 8'h07, 8'h08: return 32'h0000_ffff;
			8'h06: return 32'h339f_ff7f;
			8'h0c, 8'h0d: return 32'hffff_ffff;
			8'h10, 8'h11: return 32'h3;
			8'h1f: return 32'h13;
			default: return (r[7:3] == 5'h04) ? 32'h0f30 : 32'h0;
		endcase
	endfunction : wmask
	function automatic logic [31:0] ex(input logic [7:0] r);
		node_cfg_pkg::link_state_type s;
		s = LINK_STATE[r[2:0]];
		if (r[7:3] != 5'h04) return md[r];
		return md[r] | {6'h0, s.kind, s.dest_link, 13'h0, s.junk, s.dst_in_use, s.src_in_use};
	endfunction : ex
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
		compares++;
		if (s !== e) begin
			n_fail++;
			$display("[ERR] %s expected %h seen %h", n, e, s);
		end
	endtask : chk
	task automatic wr(input logic [7:0] r, input logic [31:0] d);
		CFG_WR = 1;
		CFG_ADDR = r;
		CFG_WDATA = d;
		step(1);
		CFG_WR = 0;
		md[r] = (md[r] & ~wmask(r)) | (d & wmask(r));
		step(1);
	endtask : wr
	task automatic rd(input logic [7:0] r);
		CFG_RD = 1;
		CFG_ADDR = r;
		step(1);
		CFG_RD = 0;
		chk("rvalid", {31'h0, CFG_RVALID}, 32'h1);
		chk("rdata", CFG_RDATA, ex(r));
		step(1);
	endtask : rd
	task automatic step(input int n);
		repeat (n) @(posedge CLK);
		#1;
	endtask : step
	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0) $display("TB: PASS");
		else $display("TB: FAIL");
		$finish;
	endtask : complete_run
	initial begin
		md = '{default: '0};
		md[8'h08] = 32'h3;
		md[8'h09] = 32'h0abc_0001;
		md[8'h0a] = {14'h02a5, 18'h1_0203};
		for (int i = 0; i < 8; i++) LINK_STATE[i] = 13'(rnd());
		step(5);
		RESET_N = 1;
		step(3);
		wr(8'h09, 32'hffff_ffff);
		wr(8'h0a, 32'hffff_ffff);
		for (int i = 5; i < 8'h2a; i++) rd(i[7:0]);
		$display("reset and read-only test done");
		for (int i = 0; i < 80; i++) begin
			t = rnd();
			a = t[3] ? 8'h20 + {5'h0, t[2:0]} : lst[t[2:0]];
			MULT_LOCKED = t[4];
			wr(a, {rnd(), rnd()});
			rd(a);
		end
		chk("ref", {16'h0, REF_DIV}, md[8'h08] & 32'hffff);
		chk("router", {16'h0, ROUTER_DIV}, md[8'h07] & 32'hffff);
		t = md[8'h06][15:0];
		chk("mult", {7'h0, CLK_MULT}, {7'h0, md[6][25:23], md[6][20:8], t[6:0], md[6][29:28]});
		for (int i = 0; i < 8; i++) chk("link", {LINK_DIR[4*i+:4], LINK_NET[2*i+:2]},
			{md[8'h20+i][11:8], md[8'h20+i][5:4]});
		$display("register traffic test done");
		for (int i = 0; i < 48; i++) begin
			t = (i % 6 == 0) ? md[5][15:0] : rnd();
			PKT_VALID = 1;
			PKT_DEST_ID = t;
			step(1);
			for (k = 15; k > 0 && t[k] == md[5][k]; k--);
			tab = {md[8'h0d], md[8'h0c]};
			chk("route", {ROUTE_VALID, ROUTE_LOCAL, ROUTE_DIR},
				(t == md[5][15:0]) ? 6'h30 : {2'b10, tab[4*k+:4]});
		end
		PKT_VALID = 0;
		$display("routing test done");
		wr(8'h1f, 32'hffff_ffff);
		rd(8'h1f);
		wr(8'h10, 32'h3);
		wr(8'h11, 32'h2);
		CORE_HALTED_FLAG = 2'b01;
		step(1);
		chk("halt", {HALT_LINE_N_OE, CORE_HALT_REQ}, 3'b111);
		md[8'h1f] = 32'h1;
		step(1);
		rd(8'h1f);
		CORE_HALTED_FLAG = 2'b10;
		step(2);
		chk("nodrive", {HALT_LINE_N_OE, CORE_HALT_REQ}, 3'b000);
		ext_n = 0;
		step(3);
		chk("extreq", {HALT_LINE_N_OE, CORE_HALT_REQ}, 3'b011);
		md[8'h1f] = 32'h10;
		rd(8'h1f);
		ext_n = 1;
		$display("halt line test done");
		complete_run();
	end
endmodule : tb_router_node_config_bank
